// File: hdl/pll1_cfg_consts.svh
`ifndef PLL1_CFG_CONSTS_SVH
`define PLL1_CFG_CONSTS_SVH
// register byte addresses are four times the register index
`define IDX_FILTER_A_SET0   8'h20
`define IDX_FILTER_A_SET1   8'h21
`define IDX_FILTER_A_SET2   8'h22
`define IDX_FILTER_A_SET3   8'h23
`define IDX_FILTER_CAPS_SET0 8'h24
`define IDX_FILTER_CAPS_SET1 8'h25
`define IDX_FILTER_CAPS_SET2 8'h26
`define IDX_FILTER_CAPS_SET3 8'h27
`define IDX_PRESCALER_SET0  8'h28
`define IDX_PRESCALER_SET1  8'h29
`define IDX_PRESCALER_SET2  8'h2A
`define IDX_PRESCALER_SET3  8'h2B
`define IDX_MODE_CTRL       8'h30
`define IDX_ACTIVE_STATUS   8'h31
`define ADDR_LSB            2
`define RESET_BYTE          8'h00
`define SET_ZERO            2'h0
`define ODIV_SEL_BIT        7
`define PUMP_MSB            6
`define PUMP_LSB            4
`define RZ_MSB              3
`define RZ_LSB              0
`define CP_MSB              7
`define CP_LSB              4
`define CZ_MSB              3
`define CZ_LSB              0
`define MODE_MFC_BIT        0
`define MODE_GIN_EN_BIT     1
`define PUMP_BASE_UA        10'h005
`define RZ_MIN_OHM          16'h012C
`define RZ_STEP_OHM         16'h03E8
`define CZ_MIN_FF           16'h1770
`define CZ_STEP_FF          16'h6A40
`define CP_MIN_FF           16'h0514
`define CP_STEP_FF          16'h02EE
`endif

// File: hdl/pll1_cfg_pkg.sv
package pll1_cfg_pkg;
  typedef struct packed {
    logic       out_div_cfg_select;
    logic [2:0] pump_current_code;
    logic [3:0] zero_resistor_code;
    logic [3:0] pole_cap_code;
    logic [3:0] zero_cap_code;
    logic [7:0] input_prescaler_value;
  } cfg_set_t;

  typedef struct packed {
    logic [9:0]  pump_current_ua;
    logic [15:0] zero_resistor_ohm;
    logic [15:0] zero_cap_ff;
    logic [15:0] pole_cap_ff;
  } analog_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ACK  = 2'b01
  } bus_state_t;
endpackage

// File: hdl/pll1_cfg_regs.sv
// Operation
// - four loop-filter copies, one per configuration set, each reset to zero
// - select inputs disabled unless multi-function mode and the input enable bit are both set: use configuration set zero
// - each set holds a bit choosing one of two output-divider configurations
// - divider selector acts only in multi-function mode; reset picks config zero
// - resistor code maps linearly: minimum plus fixed step per code
// - zero-capacitor code maps linearly: minimum plus fixed step per code
// - pole-capacitor code maps linearly: minimum plus fixed step per code
// - pump current is base unit times two to the code
// - four 8-bit prescaler values, one per set, each reset to zero
//
// Design decision made here: register access over Avalon-MM.
`include "pll1_cfg_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module pll1_cfg_regs (
  input  wire logic                   CLK,
  input  wire logic                   RST_N,
  input  wire logic [7:0]             AVS_ADDRESS,
  input  wire logic                   AVS_READ,
  input  wire logic                   AVS_WRITE,
  input  wire logic [31:0]            AVS_WRITEDATA,
  input  wire logic [3:0]             AVS_BYTEENABLE,
  output logic      [31:0]            AVS_READDATA,
  output logic                        AVS_WAITREQUEST,
  input  wire logic [1:0]             CONFIG_SELECT_INPUTS,
  output pll1_cfg_pkg::cfg_set_t      ACTIVE_CFG,
  output pll1_cfg_pkg::analog_t       ANALOG,
  output logic      [1:0]             ACTIVE_SET
);
  logic [7:0]               filter_a_ff    [4];
  logic [7:0]               filter_caps_ff [4];
  logic [7:0]               prescaler_ff   [4];

  logic                     mfc_mode_ff;
  logic                     gin_enable_ff;
  logic [1:0]               sel_meta_ff;
  logic [1:0]               sel_sync_ff;

  pll1_cfg_pkg::bus_state_t state_ff;
  logic [5:0]               idx;
  logic                     wr_take;
  logic                     rd_take;
  logic                     wr_byte;
  logic                     wr_mode;
  logic [3:0]               wr_filter_a;
  logic [3:0]               wr_filter_caps;
  logic [3:0]               wr_prescaler;
  logic [7:0]               rd_byte;

  logic [1:0]               nxt_set;
  pll1_cfg_pkg::cfg_set_t   set_view [4];
  pll1_cfg_pkg::cfg_set_t   nxt_cfg;
  pll1_cfg_pkg::analog_t    nxt_analog;
  logic [9:0]               pump_ua;

  assign idx = AVS_ADDRESS[7:`ADDR_LSB];
  // waitrequest low for exactly one cycle after the request is seen
  assign wr_take = AVS_WRITE && (state_ff == pll1_cfg_pkg::BUS_ACK);
  assign rd_take = AVS_READ && (state_ff == pll1_cfg_pkg::BUS_ACK);
  // byte lane 0 carries every register; the other lanes are ignored
  assign wr_byte = wr_take && AVS_BYTEENABLE[0];
  assign wr_mode = wr_byte && (idx == 6'(`IDX_MODE_CTRL));

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_ff <= pll1_cfg_pkg::BUS_IDLE;
    end else begin
      case (state_ff)
        pll1_cfg_pkg::BUS_IDLE: begin
          if (AVS_READ || AVS_WRITE) begin
            state_ff <= pll1_cfg_pkg::BUS_ACK;
          end
        end
        pll1_cfg_pkg::BUS_ACK: begin
          state_ff <= pll1_cfg_pkg::BUS_IDLE;
        end
        default: begin
          state_ff <= pll1_cfg_pkg::BUS_IDLE;
        end
      endcase
    end
  end

  // follows the idle-to-ack step so the pin comes straight from a flop
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      AVS_WAITREQUEST <= 1'b1;
    end else if (state_ff == pll1_cfg_pkg::BUS_IDLE && (AVS_READ || AVS_WRITE)) begin
      AVS_WAITREQUEST <= 1'b0;
    end else begin
      AVS_WAITREQUEST <= 1'b1;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_set
      assign wr_filter_a[g]    = wr_byte && (idx == 6'(`IDX_FILTER_A_SET0 + g));
      assign wr_filter_caps[g] = wr_byte && (idx == 6'(`IDX_FILTER_CAPS_SET0 + g));
      assign wr_prescaler[g]   = wr_byte && (idx == 6'(`IDX_PRESCALER_SET0 + g));

      always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
          filter_a_ff[g] <= `RESET_BYTE;
        end else if (wr_filter_a[g]) begin
          filter_a_ff[g] <= AVS_WRITEDATA[7:0];
        end
      end

      always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
          filter_caps_ff[g] <= `RESET_BYTE;
        end else if (wr_filter_caps[g]) begin
          filter_caps_ff[g] <= AVS_WRITEDATA[7:0];
        end
      end

      always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
          prescaler_ff[g] <= `RESET_BYTE;
        end else if (wr_prescaler[g]) begin
          prescaler_ff[g] <= AVS_WRITEDATA[7:0];
        end
      end

      always_comb begin
        set_view[g].out_div_cfg_select    = filter_a_ff[g][`ODIV_SEL_BIT];
        set_view[g].pump_current_code     = filter_a_ff[g][`PUMP_MSB:`PUMP_LSB];
        set_view[g].zero_resistor_code    = filter_a_ff[g][`RZ_MSB:`RZ_LSB];
        set_view[g].pole_cap_code         = filter_caps_ff[g][`CP_MSB:`CP_LSB];
        set_view[g].zero_cap_code         = filter_caps_ff[g][`CZ_MSB:`CZ_LSB];
        set_view[g].input_prescaler_value = prescaler_ff[g];
      end
    end
  endgenerate

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      mfc_mode_ff <= 1'b0;
    end else if (wr_mode) begin
      mfc_mode_ff <= AVS_WRITEDATA[`MODE_MFC_BIT];
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      gin_enable_ff <= 1'b0;
    end else if (wr_mode) begin
      gin_enable_ff <= AVS_WRITEDATA[`MODE_GIN_EN_BIT];
    end
  end

  // pins come from outside the clock domain; only the second stage is read
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      sel_meta_ff <= `SET_ZERO;
    end else begin
      sel_meta_ff <= CONFIG_SELECT_INPUTS;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      sel_sync_ff <= `SET_ZERO;
    end else begin
      sel_sync_ff <= sel_meta_ff;
    end
  end

  // pins pick the set only when enabled in multi-function mode
  always_comb begin
    case ({mfc_mode_ff, gin_enable_ff})
      2'h3: begin
        nxt_set = sel_sync_ff;
      end
      default: begin
        nxt_set = `SET_ZERO;
      end
    endcase
  end

  // whole set taken through one index, so fields never mix sets
  always_comb begin
    case (nxt_set)
      2'h0: begin
        nxt_cfg = set_view[0];
      end
      2'h1: begin
        nxt_cfg = set_view[1];
      end
      2'h2: begin
        nxt_cfg = set_view[2];
      end
      2'h3: begin
        nxt_cfg = set_view[3];
      end
      default: begin
        nxt_cfg = set_view[0];
      end
    endcase
    if (!mfc_mode_ff) begin
      nxt_cfg.out_div_cfg_select = 1'b0;
    end
  end

  always_comb begin
    case (nxt_cfg.pump_current_code)
      3'h0: begin
        pump_ua = `PUMP_BASE_UA;
      end
      3'h1: begin
        pump_ua = `PUMP_BASE_UA << 3'h1;
      end
      3'h2: begin
        pump_ua = `PUMP_BASE_UA << 3'h2;
      end
      3'h3: begin
        pump_ua = `PUMP_BASE_UA << 3'h3;
      end
      3'h4: begin
        pump_ua = `PUMP_BASE_UA << 3'h4;
      end
      3'h5: begin
        pump_ua = `PUMP_BASE_UA << 3'h5;
      end
      3'h6: begin
        pump_ua = `PUMP_BASE_UA << 3'h6;
      end
      3'h7: begin
        pump_ua = `PUMP_BASE_UA << 3'h7;
      end
      default: begin
        pump_ua = `PUMP_BASE_UA;
      end
    endcase
  end

  // analog values in integer units: ohm, femtofarad (zero cap in 10 fF), microamp
  always_comb begin
    nxt_analog.pump_current_ua   = pump_ua;
    nxt_analog.zero_resistor_ohm = 16'(`RZ_MIN_OHM
                                   + `RZ_STEP_OHM * nxt_cfg.zero_resistor_code);
    // 16 bits cannot hold the top zero-cap codes in fF; kept in units of 10 fF
    nxt_analog.zero_cap_ff       = 16'((`CZ_MIN_FF
                                   + `CZ_STEP_FF * 20'(nxt_cfg.zero_cap_code)) / 10);
    nxt_analog.pole_cap_ff       = 16'(`CP_MIN_FF
                                   + `CP_STEP_FF * nxt_cfg.pole_cap_code);
  end

  // one register stage so every field changes on the same edge
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ACTIVE_CFG <= '0;
    end else begin
      ACTIVE_CFG <= nxt_cfg;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ANALOG <= '0;
    end else begin
      ANALOG <= nxt_analog;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ACTIVE_SET <= `SET_ZERO;
    end else begin
      ACTIVE_SET <= nxt_set;
    end
  end

  always_comb begin
    rd_byte = `RESET_BYTE;
    case (idx)
      6'(`IDX_FILTER_A_SET0): begin
        rd_byte = filter_a_ff[0];
      end
      6'(`IDX_FILTER_A_SET1): begin
        rd_byte = filter_a_ff[1];
      end
      6'(`IDX_FILTER_A_SET2): begin
        rd_byte = filter_a_ff[2];
      end
      6'(`IDX_FILTER_A_SET3): begin
        rd_byte = filter_a_ff[3];
      end
      6'(`IDX_FILTER_CAPS_SET0): begin
        rd_byte = filter_caps_ff[0];
      end
      6'(`IDX_FILTER_CAPS_SET1): begin
        rd_byte = filter_caps_ff[1];
      end
      6'(`IDX_FILTER_CAPS_SET2): begin
        rd_byte = filter_caps_ff[2];
      end
      6'(`IDX_FILTER_CAPS_SET3): begin
        rd_byte = filter_caps_ff[3];
      end
      6'(`IDX_PRESCALER_SET0): begin
        rd_byte = prescaler_ff[0];
      end
      6'(`IDX_PRESCALER_SET1): begin
        rd_byte = prescaler_ff[1];
      end
      6'(`IDX_PRESCALER_SET2): begin
        rd_byte = prescaler_ff[2];
      end
      6'(`IDX_PRESCALER_SET3): begin
        rd_byte = prescaler_ff[3];
      end
      6'(`IDX_MODE_CTRL): begin
        rd_byte = {6'h00, gin_enable_ff, mfc_mode_ff};
      end
      6'(`IDX_ACTIVE_STATUS): begin
        rd_byte = {6'h00, ACTIVE_SET};
      end
      default: begin
        rd_byte = `RESET_BYTE;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      AVS_READDATA <= 32'h0000_0000;
    end else if (AVS_READ && state_ff == pll1_cfg_pkg::BUS_IDLE) begin
      AVS_READDATA <= {24'h000000, rd_byte};
    end else if (rd_take) begin
      AVS_READDATA <= AVS_READDATA;
    end
  end
endmodule
`default_nettype wire

// File: bench/pll1_cfg_checker.sv
`timescale 1ns/1ps
`default_nettype none
module pll1_cfg_checker (
  input wire logic                   CLK,
  input wire logic                   RST_N,
  input wire logic [7:0]             AVS_ADDRESS,
  input wire logic                   AVS_READ,
  input wire logic                   AVS_WRITE,
  input wire logic [31:0]            AVS_WRITEDATA,
  input wire logic [3:0]             AVS_BYTEENABLE,
  input wire logic [31:0]            AVS_READDATA,
  input wire logic                   AVS_WAITREQUEST,
  input wire logic [1:0]             CONFIG_SELECT_INPUTS,
  input wire pll1_cfg_pkg::cfg_set_t ACTIVE_CFG,
  input wire pll1_cfg_pkg::analog_t  ANALOG,
  input wire logic [1:0]             ACTIVE_SET
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  a_wait_answer: assert property ($rose(AVS_READ | AVS_WRITE) |=> !AVS_WAITREQUEST)
    else $error("request not answered after one wait cycle");
  a_wait_single: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("waitrequest low for more than one cycle");
  a_idle_wait: assert property (!AVS_READ && !AVS_WRITE |=> AVS_WAITREQUEST)
    else $error("waitrequest low without a request");
  a_read_upper_zero: assert property (!AVS_WAITREQUEST |-> AVS_READDATA[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  // analog outputs register on the same edge as the set; judged once the set has held three cycles
  a_pump_binary: assert property ($stable(ACTIVE_CFG)[*3] |-> ANALOG.pump_current_ua == 10'(10'h005 << ACTIVE_CFG.pump_current_code))
    else $error("pump current not binary weighted");
  a_rz_linear: assert property ($stable(ACTIVE_CFG)[*3] |-> ANALOG.zero_resistor_ohm == 16'(16'h012C + 16'h03E8 * ACTIVE_CFG.zero_resistor_code))
    else $error("resistor value not linear");
  a_cp_linear: assert property ($stable(ACTIVE_CFG)[*3] |-> ANALOG.pole_cap_ff == 16'(16'h0514 + 16'h02EE * ACTIVE_CFG.pole_cap_code))
    else $error("pole capacitor value not linear");
  a_cz_linear: assert property ($stable(ACTIVE_CFG)[*3] |-> ANALOG.zero_cap_ff ==
    16'((20'h01770 + 20'h06A40 * ACTIVE_CFG.zero_cap_code) / 10))
    else $error("zero capacitor value not linear");
  a_set_from_pins: assert property ($stable(CONFIG_SELECT_INPUTS)[*4] ##0 ACTIVE_SET != 2'h0
    |-> ACTIVE_SET == CONFIG_SELECT_INPUTS)
    else $error("active set differs from select inputs");
  a_cfg_holds: assert property ((!AVS_WRITE && $stable(CONFIG_SELECT_INPUTS))[*4] |-> $stable(ACTIVE_CFG) && $stable(ACTIVE_SET))
    else $error("active configuration changed without cause");
  c_write: cover property (AVS_WRITE && !AVS_WAITREQUEST);
  c_read: cover property (AVS_READ && !AVS_WAITREQUEST);
  c_set3: cover property (ACTIVE_SET == 2'h3);
endmodule
`default_nettype wire

// File: bench/tb_pll1_cfg_regs.sv
`timescale 1ns/1ps
`default_nettype none
module tb_pll1_cfg_regs;
  logic                   CLK = 1'b0;
  logic                   RST_N = 1'b0;
  logic [7:0]             AVS_ADDRESS = 8'h00;
  logic                   AVS_READ = 1'b0;
  logic                   AVS_WRITE = 1'b0;
  logic [31:0]            AVS_WRITEDATA = 32'h0;
  logic [3:0]             AVS_BYTEENABLE = 4'hF;
  logic [31:0]            AVS_READDATA;
  logic                   AVS_WAITREQUEST;
  logic [1:0]             CONFIG_SELECT_INPUTS = 2'h0;
  pll1_cfg_pkg::cfg_set_t ACTIVE_CFG;
  pll1_cfg_pkg::analog_t  ANALOG;
  logic [1:0]             ACTIVE_SET;
  int                     fails = 0;
  int                     checks_done = 0;
  int                     cyc = 0;
  logic [31:0]            rd;
  always #10 CLK = ~CLK;
  pll1_cfg_regs uut (.CLK(CLK), .RST_N(RST_N), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .CONFIG_SELECT_INPUTS(CONFIG_SELECT_INPUTS), .ACTIVE_CFG(ACTIVE_CFG), .ANALOG(ANALOG),
    .ACTIVE_SET(ACTIVE_SET));
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      conclude();
    end
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] want);
    checks_done++;
    if (seen !== want) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, want, seen);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d, input logic [3:0] be);
    @(posedge CLK);
    AVS_ADDRESS <= {idx[5:0], 2'b00};
    AVS_READ <= !wr;
    AVS_WRITE <= wr;
    AVS_WRITEDATA <= {24'h0, d};
    AVS_BYTEENABLE <= be;
    do @(posedge CLK); while (AVS_WAITREQUEST !== 1'b0);
    rd = AVS_READDATA;
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
  endtask
  function automatic logic [7:0] rv(input int i);
    int k = i % 4;
    if (i < 8'h24) return {~k[0], 3'(k + 4), 4'(k * 5)};
    if (i < 8'h28) return {4'(k + 9), 4'(k + 2)};
    return 8'(8'h11 * (k + 1));
  endfunction
  // outputs trail the pins by three cycles, so five is settled
  task automatic chk_set(input int s, input logic odiv_on);
    logic [7:0] a;
    logic [7:0] c;
    repeat (5) @(posedge CLK);
    a = rv(8'h20 + s);
    c = rv(8'h24 + s);
    check("set", 32'(ACTIVE_SET), 32'(s));
    check("cfg", 32'(ACTIVE_CFG), 32'({a[7] & odiv_on, a[6:0], c, rv(8'h28 + s)}));
    check("pump", 32'(ANALOG.pump_current_ua), 32'(5) << a[6:4]);
    check("rz", 32'(ANALOG.zero_resistor_ohm), 32'(300 + 1000 * a[3:0]));
    check("cp", 32'(ANALOG.pole_cap_ff), 32'(1300 + 750 * c[7:4]));
    check("cz", 32'(ANALOG.zero_cap_ff), 32'((6000 + 27200 * c[3:0]) / 10));
  endtask
  initial begin
    repeat (6) @(posedge CLK);
    RST_N <= 1'b1;
    for (int i = 8'h20; i <= 8'h30; i++) begin
      bus(1'b0, 8'(i), 8'h00, 4'hF);
      check("reset reg", rd, 32'h0);
    end
    check("reset cfg", 32'(ACTIVE_CFG), 32'h0);
    $display("test reset done");
    for (int i = 8'h20; i < 8'h2C; i++) bus(1'b1, 8'(i), rv(i), 4'hF);
    bus(1'b1, 8'h20, 8'h7E, 4'hE);
    bus(1'b1, 8'h3F, 8'h5A, 4'hF);
    for (int i = 8'h20; i < 8'h2C; i++) begin
      bus(1'b0, 8'(i), 8'h00, 4'hF);
      check("readback", rd, 32'(rv(i)));
    end
    bus(1'b0, 8'h3F, 8'h00, 4'hF);
    check("unmapped", rd, 32'h0);
    $display("test registers done");
    CONFIG_SELECT_INPUTS <= 2'h3;
    chk_set(0, 1'b0);
    bus(1'b1, 8'h30, 8'h03, 4'hF);
    bus(1'b0, 8'h30, 8'h00, 4'hF);
    check("mode", rd, 32'h3);
    for (int s = 0; s < 4; s++) begin
      CONFIG_SELECT_INPUTS <= 2'(s);
      chk_set(s, 1'b1);
      bus(1'b0, 8'h31, 8'h00, 4'hF);
      check("status", rd, 32'(s));
    end
    bus(1'b1, 8'h30, 8'h01, 4'hF);
    CONFIG_SELECT_INPUTS <= 2'h2;
    chk_set(0, 1'b1);
    $display("test selection done");
    conclude();
  end
endmodule
bind pll1_cfg_regs pll1_cfg_checker chk (.CLK(CLK), .RST_N(RST_N), .AVS_ADDRESS(AVS_ADDRESS),
  .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
  .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .CONFIG_SELECT_INPUTS(CONFIG_SELECT_INPUTS), .ACTIVE_CFG(ACTIVE_CFG), .ANALOG(ANALOG),
  .ACTIVE_SET(ACTIVE_SET));
`default_nettype wire
